// ### src/pidq_defines.svh
// Constants of the product id query link: codes, record contents and timing
`ifndef PIDQ_DEFINES_SVH
`define PIDQ_DEFINES_SVH

`define PIDQ_CLK_HZ 10000000
`define PIDQ_HOST_BAUD 115200
`define PIDQ_HOST_BIT_CYC (`PIDQ_CLK_HZ / `PIDQ_HOST_BAUD)
`define PIDQ_DEF_BIT_CYC 16'h0056
`define PIDQ_MIN_BIT_CYC 16'h0004
`define PIDQ_TIMEOUT_BITS 40
`define PIDQ_DEV_RST_CYC 4'h8

`define PIDQ_MATCH1_A 8'h86
`define PIDQ_MATCH1_B 8'h30
`define PIDQ_MATCH2_A 8'h79
`define PIDQ_MATCH2_B 8'hcf
`define PIDQ_CMD_QUERY 8'hc0
`define PIDQ_ERR_FRAME 8'ha1
`define PIDQ_ERR_BREAK 8'ha3
`define PIDQ_ERR_CMD 8'h63
`define PIDQ_ERR_REPEAT 2'h3

`define PIDQ_START_MARK 8'h3a
`define PIDQ_PAYLOAD_LEN 8'h13
`define PIDQ_ADDR_LEN 8'h03
`define PIDQ_RSV_FIXED 8'hfd
`define PIDQ_FLASH_SIZE_FIELD 5'h10
`define PIDQ_FLASH_BLOCKS 8'h01
`define PIDQ_FLASH_FIRST 24'h008000
`define PIDQ_FLASH_LAST 24'h00ffff
// Loader RAM window stops short of the boot program work area
`define PIDQ_RAM_FIRST 24'h000060
`define PIDQ_RAM_LAST 24'h00083f
`define PIDQ_REC_LAST 5'h15
`define PIDQ_SUM_FIRST 5'h02

`endif

// ### src/pidq_pkg.sv
// Types shared by both ends of the product id query link
package pidq_pkg;
    typedef logic [7:0] pidq_byte_t;

    typedef enum logic [3:0] {
        DS_IDLE  = 4'b0000,
        DS_LOW   = 4'b0001,
        DS_HIGH  = 4'b0010,
        DS_CLASS = 4'b0011,
        DS_TAIL  = 4'b0100,
        DS_ECHO1 = 4'b0101,
        DS_WAIT2 = 4'b0110,
        DS_ECHO2 = 4'b0111,
        DS_CMD   = 4'b1000,
        DS_ECHOC = 4'b1001,
        DS_REC   = 4'b1010,
        DS_ERR   = 4'b1011,
        DS_HALT  = 4'b1100
    } pidq_dev_state_t;

    typedef enum logic [2:0] {
        HS_IDLE  = 3'b000,
        HS_SEND  = 3'b001,
        HS_ECHO  = 3'b010,
        HS_REC   = 3'b011,
        HS_ERRW  = 3'b100,
        HS_RESET = 3'b101
    } pidq_host_state_t;
endpackage

// ### src/pidq_if.sv
// Serial link between the programming controller and the device
`timescale 1ns/1ps
interface pidq_if;
    logic ctrl_line;
    logic dev_line;
    logic dev_reset;
    modport dev (
        input ctrl_line,
        input dev_reset,
        output dev_line
    );
    modport ctrl (
        output ctrl_line,
        output dev_reset,
        input dev_line
    );
endinterface

// ### src/pidq_uart.sv
// Byte serialiser and deserialiser with a run-time bit period
`timescale 1ns/1ps
module pidq_uart
    import pidq_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [15:0] bit_cyc,
    input wire logic rx_en,
    input wire logic tx_valid,
    input wire pidq_byte_t tx_data,
    output logic tx_ready,
    output logic tx_line,
    input wire logic rx_line,
    output logic rx_valid,
    output pidq_byte_t rx_data,
    output logic rx_frame_err
);
    logic tx_busy_q;
    logic [15:0] tx_cnt_q;
    logic [3:0] tx_bit_q;
    logic [8:0] tx_sh_q;
    logic rx_busy_q;
    logic [15:0] rx_cnt_q;
    logic [3:0] rx_bit_q;
    pidq_byte_t rx_sh_q;

    wire tx_go = tx_valid && !tx_busy_q;
    wire tx_tick = tx_cnt_q == bit_cyc - 16'h0001;
    // First sample lands mid start bit, later ones a full period apart
    wire [15:0] rx_tgt = (rx_bit_q == 4'h0) ? {1'b0, bit_cyc[15:1]} : bit_cyc - 16'h0001;
    wire rx_tick = rx_busy_q && rx_cnt_q == rx_tgt;

    assign tx_ready = !tx_busy_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            tx_busy_q <= 1'b0;
            tx_cnt_q <= 16'h0000;
            tx_bit_q <= 4'h0;
            tx_sh_q <= 9'h1ff;
            tx_line <= 1'b1;
        end else if (tx_go) begin
            tx_busy_q <= 1'b1;
            tx_cnt_q <= 16'h0000;
            tx_bit_q <= 4'h0;
            tx_sh_q <= {1'b1, tx_data};
            tx_line <= 1'b0;
        end else if (tx_busy_q) begin
            tx_cnt_q <= tx_tick ? 16'h0000 : tx_cnt_q + 16'h0001;
            if (tx_tick && tx_bit_q == 4'h9) begin
                tx_busy_q <= 1'b0;
            end else if (tx_tick) begin
                tx_line <= tx_sh_q[0];
                tx_sh_q <= {1'b1, tx_sh_q[8:1]};
                tx_bit_q <= tx_bit_q + 4'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset || !rx_en) begin
            rx_busy_q <= 1'b0;
            rx_cnt_q <= 16'h0000;
            rx_bit_q <= 4'h0;
            rx_sh_q <= 8'h00;
            rx_valid <= 1'b0;
            rx_data <= 8'h00;
            rx_frame_err <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            if (!rx_busy_q && !rx_line) begin
                rx_busy_q <= 1'b1;
                rx_cnt_q <= 16'h0000;
                rx_bit_q <= 4'h0;
            end else if (rx_tick) begin
                rx_cnt_q <= 16'h0000;
                rx_bit_q <= rx_bit_q + 4'h1;
                if (rx_bit_q == 4'h0 && rx_line) begin
                    rx_busy_q <= 1'b0;
                end else if (rx_bit_q == 4'h9) begin
                    rx_busy_q <= 1'b0;
                    rx_valid <= 1'b1;
                    rx_data <= rx_sh_q;
                    rx_frame_err <= !rx_line;
                end else if (rx_bit_q != 4'h0) begin
                    rx_sh_q <= {rx_line, rx_sh_q[7:1]};
                end
            end else if (rx_busy_q) begin
                rx_cnt_q <= rx_cnt_q + 16'h0001;
            end
        end
    end
endmodule

// ### src/pidq_device.sv
// Device end: baud detection, matching echoes, query command and id record
`timescale 1ns/1ps
`include "pidq_defines.svh"
module pidq_device
    import pidq_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    pidq_if.dev lnk,
    output logic session_open,
    output logic halted,
    output logic [15:0] bit_cycles
);
    pidq_dev_state_t state_q;
    logic [15:0] low_q;
    logic [15:0] high_q;
    logic [15:0] tail_q;
    logic accept_q;
    pidq_byte_t echo_q;
    pidq_byte_t err_code_q;
    logic [1:0] err_cnt_q;
    logic [4:0] idx_q;
    pidq_byte_t sum_q;

    // Host reset pin restarts everything, halted state included
    wire rst = reset || lnk.dev_reset;

    wire tx_ready;
    wire rx_valid;
    wire pidq_byte_t rx_data;
    wire rx_frame_err;

    // Low run then high run of the first byte: 0x86 gives 2 and 2 bits,
    // 0x30 gives 5 and 2 bits, so the high run is always two bit times
    wire [19:0] l4 = {2'b00, low_q, 2'b00};
    wire [19:0] h1 = {4'h0, high_q};
    wire is_m1a = l4 >= h1 * 20'h00003 && l4 <= h1 * 20'h00005;
    wire is_m1b = l4 >= h1 * 20'h00008 && l4 <= h1 * 20'h0000c;
    // High run spans high_q + 1 clocks: its first high sample only moved the state on
    wire [16:0] high_run = {1'b0, high_q} + 17'h00001;
    wire [15:0] derived_bit = high_run[16:1];
    wire baud_ok = derived_bit >= `PIDQ_MIN_BIT_CYC;
    wire m2_ok = !rx_frame_err && (rx_data == `PIDQ_MATCH2_A || rx_data == `PIDQ_MATCH2_B);
    wire cmd_ok = !rx_frame_err && rx_data == `PIDQ_CMD_QUERY;
    wire pidq_byte_t cmd_err = !rx_frame_err ? `PIDQ_ERR_CMD
                             : (rx_data == 8'h00 ? `PIDQ_ERR_BREAK : `PIDQ_ERR_FRAME);
    wire sum_take = idx_q >= `PIDQ_SUM_FIRST && idx_q < `PIDQ_REC_LAST;

    function automatic pidq_byte_t rec_byte(input logic [4:0] i, input pidq_byte_t sum);
        pidq_byte_t b;
        b = 8'h00;
        unique case (i)
            5'h00: b = `PIDQ_START_MARK;
            5'h01: b = `PIDQ_PAYLOAD_LEN;
            5'h02: b = `PIDQ_ADDR_LEN;
            5'h03: b = `PIDQ_RSV_FIXED;
            5'h04, 5'h05, 5'h06: b = 8'h00;
            5'h07: b = {`PIDQ_FLASH_SIZE_FIELD, 3'b000};
            5'h08: b = `PIDQ_FLASH_BLOCKS;
            5'h09: b = 8'(`PIDQ_FLASH_FIRST >> 16);
            5'h0a: b = 8'(`PIDQ_FLASH_FIRST >> 8);
            5'h0b: b = 8'(`PIDQ_FLASH_FIRST);
            5'h0c: b = 8'(`PIDQ_FLASH_LAST >> 16);
            5'h0d: b = 8'(`PIDQ_FLASH_LAST >> 8);
            5'h0e: b = 8'(`PIDQ_FLASH_LAST);
            5'h0f: b = 8'(`PIDQ_RAM_FIRST >> 16);
            5'h10: b = 8'(`PIDQ_RAM_FIRST >> 8);
            5'h11: b = 8'(`PIDQ_RAM_FIRST);
            5'h12: b = 8'(`PIDQ_RAM_LAST >> 16);
            5'h13: b = 8'(`PIDQ_RAM_LAST >> 8);
            5'h14: b = 8'(`PIDQ_RAM_LAST);
            default: b = 8'h00 - sum;
        endcase
        return b;
    endfunction

    wire pidq_byte_t rec_now = rec_byte(idx_q, sum_q);
    wire sending = state_q == DS_ECHO1 || state_q == DS_ECHO2 || state_q == DS_ECHOC
                || state_q == DS_REC || state_q == DS_ERR;
    wire tx_go = sending && tx_ready;
    wire pidq_byte_t tx_byte = state_q == DS_REC ? rec_now
                             : (state_q == DS_ERR ? err_code_q : echo_q);
    wire rx_on = state_q >= DS_ECHO1 && state_q <= DS_REC;

    pidq_uart u_uart (
        .clk(clk),
        .reset(rst),
        .bit_cyc(bit_cycles),
        .rx_en(rx_on),
        .tx_valid(tx_go),
        .tx_data(tx_byte),
        .tx_ready(tx_ready),
        .tx_line(lnk.dev_line),
        .rx_line(lnk.ctrl_line),
        .rx_valid(rx_valid),
        .rx_data(rx_data),
        .rx_frame_err(rx_frame_err)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= DS_IDLE;
            low_q <= 16'h0000;
            high_q <= 16'h0000;
            tail_q <= 16'h0000;
            accept_q <= 1'b0;
            echo_q <= 8'h00;
            err_code_q <= 8'h00;
            err_cnt_q <= 2'h0;
            idx_q <= 5'h00;
            sum_q <= 8'h00;
            bit_cycles <= `PIDQ_DEF_BIT_CYC;
            session_open <= 1'b0;
            halted <= 1'b0;
        end else begin
            unique case (state_q)
                DS_IDLE: begin
                    low_q <= 16'h0000;
                    high_q <= 16'h0000;
                    if (!lnk.ctrl_line) begin
                        state_q <= DS_LOW;
                    end
                end
                DS_LOW: begin
                    if (lnk.ctrl_line) begin
                        state_q <= DS_HIGH;
                    end else if (low_q != 16'hffff) begin
                        low_q <= low_q + 16'h0001;
                    end
                end
                DS_HIGH: begin
                    if (!lnk.ctrl_line) begin
                        state_q <= DS_CLASS;
                    end else if (high_q != 16'hffff) begin
                        high_q <= high_q + 16'h0001;
                    end
                end
                DS_CLASS: begin
                    // Rejected bytes are swallowed: no echo, back to listening
                    accept_q <= baud_ok && (is_m1a || is_m1b);
                    echo_q <= is_m1a ? `PIDQ_MATCH1_A : `PIDQ_MATCH1_B;
                    if (baud_ok) begin
                        bit_cycles <= derived_bit;
                    end
                    tail_q <= 16'h0000;
                    state_q <= DS_TAIL;
                end
                DS_TAIL: begin
                    // Wait two idle bit times so the rest of the byte is skipped
                    tail_q <= lnk.ctrl_line ? tail_q + 16'h0001 : 16'h0000;
                    if (tail_q == high_q) begin
                        state_q <= accept_q ? DS_ECHO1 : DS_IDLE;
                    end
                end
                DS_ECHO1: begin
                    if (tx_ready) begin
                        state_q <= DS_WAIT2;
                    end
                end
                DS_WAIT2: begin
                    if (rx_valid && m2_ok) begin
                        echo_q <= rx_data;
                        state_q <= DS_ECHO2;
                    end else if (rx_valid) begin
                        state_q <= DS_IDLE;
                    end
                end
                DS_ECHO2: begin
                    if (tx_ready) begin
                        session_open <= 1'b1;
                        state_q <= DS_CMD;
                    end
                end
                DS_CMD: begin
                    if (rx_valid && cmd_ok) begin
                        echo_q <= rx_data;
                        state_q <= DS_ECHOC;
                    end else if (rx_valid) begin
                        err_code_q <= cmd_err;
                        err_cnt_q <= 2'h0;
                        state_q <= DS_ERR;
                    end
                end
                DS_ECHOC: begin
                    if (tx_ready) begin
                        idx_q <= 5'h00;
                        sum_q <= 8'h00;
                        state_q <= DS_REC;
                    end
                end
                DS_REC: begin
                    if (tx_ready) begin
                        if (sum_take) begin
                            sum_q <= sum_q + rec_now;
                        end
                        idx_q <= idx_q + 5'h01;
                        if (idx_q == `PIDQ_REC_LAST) begin
                            state_q <= DS_CMD;
                        end
                    end
                end
                DS_ERR: begin
                    // Leave on the launch of the last copy, else a fourth one goes out
                    if (tx_ready && err_cnt_q == `PIDQ_ERR_REPEAT - 2'h1) begin
                        session_open <= 1'b0;
                        halted <= 1'b1;
                        state_q <= DS_HALT;
                    end else if (tx_ready) begin
                        err_cnt_q <= err_cnt_q + 2'h1;
                    end
                end
                DS_HALT: begin
                    state_q <= DS_HALT;
                end
                default: begin
                    state_q <= DS_IDLE;
                end
            endcase
        end
    end
endmodule

// ### src/pidq_host.sv
// Controller end: opens the session, issues the query, checks the record
`timescale 1ns/1ps
`include "pidq_defines.svh"
module pidq_host
    import pidq_pkg::*;
#(
    parameter logic [15:0] BIT_CYC = 16'(`PIDQ_HOST_BIT_CYC),
    parameter logic [15:0] TIMEOUT_CYC = 16'(`PIDQ_TIMEOUT_BITS * `PIDQ_HOST_BIT_CYC)
) (
    input wire logic clk,
    input wire logic reset,
    pidq_if.ctrl lnk,
    input wire logic start,
    input wire logic match_alt,
    output logic busy,
    output logic done,
    output logic ok,
    output logic err,
    output pidq_byte_t err_code,
    output logic rec_valid,
    output pidq_byte_t rec_data,
    output logic [4:0] rec_idx
);
    pidq_host_state_t state_q;
    logic [1:0] step_q;
    logic session_q;
    logic alt_q;
    logic [15:0] wait_q;
    logic [4:0] idx_q;
    pidq_byte_t sum_q;
    logic mark_ok_q;
    logic [1:0] err_cnt_q;
    logic [3:0] rst_cnt_q;

    wire tx_ready;
    wire rx_valid;
    wire pidq_byte_t rx_data;
    wire rx_frame_err;

    wire pidq_byte_t m1 = alt_q ? `PIDQ_MATCH1_B : `PIDQ_MATCH1_A;
    wire pidq_byte_t m2 = alt_q ? `PIDQ_MATCH2_B : `PIDQ_MATCH2_A;
    wire pidq_byte_t step_byte = step_q == 2'h0 ? m1 : (step_q == 2'h1 ? m2 : `PIDQ_CMD_QUERY);
    wire tx_go = state_q == HS_SEND && tx_ready;
    wire timeout = wait_q == TIMEOUT_CYC;
    wire echo_good = !rx_frame_err && rx_data == step_byte;
    wire is_err_code = rx_data == `PIDQ_ERR_FRAME || rx_data == `PIDQ_ERR_BREAK
                    || rx_data == `PIDQ_ERR_CMD;
    wire pidq_byte_t sum_next = sum_q + rx_data;

    pidq_uart u_uart (
        .clk(clk),
        .reset(reset),
        .bit_cyc(BIT_CYC),
        .rx_en(1'b1),
        .tx_valid(tx_go),
        .tx_data(step_byte),
        .tx_ready(tx_ready),
        .tx_line(lnk.ctrl_line),
        .rx_line(lnk.dev_line),
        .rx_valid(rx_valid),
        .rx_data(rx_data),
        .rx_frame_err(rx_frame_err)
    );

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= HS_IDLE;
            step_q <= 2'h0;
            session_q <= 1'b0;
            alt_q <= 1'b0;
            wait_q <= 16'h0000;
            idx_q <= 5'h00;
            sum_q <= 8'h00;
            mark_ok_q <= 1'b0;
            err_cnt_q <= 2'h0;
            rst_cnt_q <= 4'h0;
            lnk.dev_reset <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            ok <= 1'b0;
            err <= 1'b0;
            err_code <= 8'h00;
            rec_valid <= 1'b0;
            rec_data <= 8'h00;
            rec_idx <= 5'h00;
        end else begin
            done <= 1'b0;
            rec_valid <= 1'b0;
            wait_q <= (state_q == HS_ECHO || state_q == HS_REC || state_q == HS_ERRW)
                      && !rx_valid ? wait_q + 16'h0001 : 16'h0000;
            unique case (state_q)
                HS_IDLE: begin
                    if (start) begin
                        busy <= 1'b1;
                        ok <= 1'b0;
                        err <= 1'b0;
                        alt_q <= match_alt;
                        step_q <= session_q ? 2'h2 : 2'h0;
                        state_q <= HS_SEND;
                    end
                end
                HS_SEND: begin
                    if (tx_ready) begin
                        state_q <= HS_ECHO;
                    end
                end
                HS_ECHO: begin
                    if (rx_valid && echo_good && step_q == 2'h2) begin
                        idx_q <= 5'h00;
                        sum_q <= 8'h00;
                        state_q <= HS_REC;
                    end else if (rx_valid && echo_good) begin
                        step_q <= step_q + 2'h1;
                        state_q <= HS_SEND;
                    end else if (rx_valid && step_q == 2'h2 && is_err_code) begin
                        err_code <= rx_data;
                        err_cnt_q <= 2'h1;
                        state_q <= HS_ERRW;
                    end else if (rx_valid || timeout) begin
                        state_q <= HS_RESET;
                    end
                end
                HS_REC: begin
                    // Transmitter stays quiet until the checksum is in
                    if (rx_valid) begin
                        rec_valid <= 1'b1;
                        rec_data <= rx_data;
                        rec_idx <= idx_q;
                        idx_q <= idx_q + 5'h01;
                        if (idx_q == 5'h00) begin
                            mark_ok_q <= rx_data == `PIDQ_START_MARK;
                        end
                        if (idx_q >= `PIDQ_SUM_FIRST) begin
                            sum_q <= sum_next;
                        end
                        if (idx_q == `PIDQ_REC_LAST) begin
                            ok <= mark_ok_q && sum_next == 8'h00 && !rx_frame_err;
                            session_q <= 1'b1;
                            busy <= 1'b0;
                            done <= 1'b1;
                            state_q <= HS_IDLE;
                        end
                    end else if (timeout) begin
                        state_q <= HS_RESET;
                    end
                end
                HS_ERRW: begin
                    if (rx_valid && err_cnt_q == 2'h2) begin
                        state_q <= HS_RESET;
                    end else if (rx_valid) begin
                        err_cnt_q <= err_cnt_q + 2'h1;
                    end else if (timeout) begin
                        state_q <= HS_RESET;
                    end
                end
                HS_RESET: begin
                    // Device may be halted; only its reset pin revives it
                    lnk.dev_reset <= rst_cnt_q != `PIDQ_DEV_RST_CYC;
                    rst_cnt_q <= rst_cnt_q + 4'h1;
                    session_q <= 1'b0;
                    if (rst_cnt_q == `PIDQ_DEV_RST_CYC) begin
                        rst_cnt_q <= 4'h0;
                        err <= 1'b1;
                        busy <= 1'b0;
                        done <= 1'b1;
                        state_q <= HS_IDLE;
                    end
                end
                default: begin
                    state_q <= HS_IDLE;
                end
            endcase
        end
    end
endmodule

// ### tb/pidq_checker.sv
// Wire-level checks on the controller to device serial link
`timescale 1ns/1ps
module pidq_checker (
    input wire logic clk,
    input wire logic reset,
    input wire logic ctrl_line,
    input wire logic dev_line,
    input wire logic dev_reset
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    rst_quiet_a: assert property (dev_reset |=> dev_line)
        else $error("device line active while device held in reset");
    rst_pulse_a: assert property ($rose(dev_reset) |-> dev_reset [*8] ##1 !dev_reset)
        else $error("device reset pulse length wrong");
    dev_start_a: assert property ($fell(dev_line) |-> !dev_line [*4])
        else $error("device start bit shorter than minimum bit period");
    ctrl_start_a: assert property ($fell(ctrl_line) |-> !ctrl_line [*8])
        else $error("controller start bit too short");
    no_overlap_a: assert property (!(!ctrl_line && !dev_line))
        else $error("both ends driving low at once");
    dev_hush_a: assert property ($fell(dev_line) |-> ctrl_line [*8])
        else $error("controller sent while device started a byte");
    frame_bound_a: assert property ($fell(dev_line) |-> ##[1:1000] $rose(dev_line))
        else $error("device line stuck low beyond one frame");
    ctrl_bound_a: assert property ($fell(ctrl_line) |-> ##[1:1000] $rose(ctrl_line))
        else $error("controller line stuck low beyond one frame");

    // Main traffic and the recovery path
    cov_ctrl_c: cover property ($fell(ctrl_line));
    cov_dev_c: cover property ($fell(dev_line));
    cov_rst_c: cover property ($rose(dev_reset));
endmodule

// ### tb/product_id_query_responder_tb.sv
// Self-checking bench: host and device joined, plus a second device that the bench drives as controller for errors
`timescale 1ns/1ps
module product_id_query_responder_tb;
    import pidq_pkg::*;
    logic clk, reset, start, match_alt, busy, done, ok, err, rec_valid;
    logic session_open, halted, halted_2;
    logic [15:0] bit_cycles, bit_cycles_2;
    logic [4:0] rec_idx;
    pidq_byte_t err_code, rec_data;
    pidq_byte_t rec_q [0:21];
    int error_cnt = 0;
    int samples_checked = 0;
    localparam logic [167:0] REC = {
        8'h3a, 8'h13,
        8'h03, 8'hfd, 8'h00, 8'h00, 8'h00,
        {5'b10000, 3'b000},
        8'h01,
        8'h00, 8'h80, 8'h00,
        8'h00, 8'hff, 8'hff,
        8'h00, 8'h00, 8'h60,
        8'h00, 8'h08, 8'h3f
    };
    pidq_if lnk ();
    pidq_if lnk2 ();
    pidq_device u_pidq_device (.clk(clk), .reset(reset), .lnk(lnk),
        .session_open(session_open), .halted(halted), .bit_cycles(bit_cycles));
    pidq_device u_pidq_device_2 (.clk(clk), .reset(reset), .lnk(lnk2),
        .session_open(), .halted(halted_2), .bit_cycles(bit_cycles_2));
    pidq_host u_pidq_host (.clk(clk), .reset(reset), .lnk(lnk), .start(start),
        .match_alt(match_alt), .busy(busy), .done(done), .ok(ok), .err(err),
        .err_code(err_code), .rec_valid(rec_valid), .rec_data(rec_data), .rec_idx(rec_idx));
    pidq_checker u_pidq_checker (.clk(clk), .reset(reset), .ctrl_line(lnk.ctrl_line),
        .dev_line(lnk.dev_line), .dev_reset(lnk.dev_reset));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        if (rec_valid === 1'b1) begin
            rec_q[rec_idx] <= rec_data;
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("checks=%0d errors=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Whole exchange through the host; record compared byte by byte
    task automatic query(input logic alt);
        int n;
        pidq_byte_t sum;
        n = 0;
        sum = 8'h00;
        foreach (rec_q[i]) rec_q[i] = 8'hxx;
        match_alt = alt;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        while (done !== 1'b1 && n < 60000) begin
            @(negedge clk);
            n++;
        end
        check(busy, 1'b0);
        // Checksum byte lands in rec_q one edge after done
        @(negedge clk);
        check(ok, 1'b1);
        check(err, 1'b0);
        check(session_open, 1'b1);
        check(halted, 1'b0);
        check(bit_cycles, 16'h0056);
        for (int i = 0; i < 21; i++) begin
            check(rec_q[i], REC[167-8*i -: 8]);
            if (i > 1) sum += REC[167-8*i -: 8];
        end
        sum = -sum;
        check(rec_q[21], sum);
    endtask
    // Bench acts as controller on the second link, at 86 clocks a bit
    task automatic send(input pidq_byte_t b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            lnk2.ctrl_line = f[i];
            // Return at mid stop bit: the echo may start before the stop bit ends
            repeat (i == 9 ? 43 : 86) @(negedge clk);
        end
    endtask
    task automatic recv(output pidq_byte_t b);
        int n;
        n = 0;
        b = 8'h00;
        while (lnk2.dev_line !== 1'b0 && n < 4000) begin
            @(negedge clk);
            n++;
        end
        repeat (43) @(negedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (86) @(negedge clk);
            b[i] = lnk2.dev_line;
        end
        // Stop at mid stop bit so the start edge of a back-to-back next byte is not missed
        repeat (86) @(negedge clk);
    endtask
    task automatic t_bad_cmd;
        pidq_byte_t b;
        logic quiet;
        quiet = 1'b1;
        send(8'h30);
        recv(b);
        check(b, 8'h30);
        check(bit_cycles_2, 16'h0056);
        send(8'hcf);
        recv(b);
        check(b, 8'hcf);
        send(8'h55);
        for (int i = 0; i < 3; i++) begin
            recv(b);
            check(b, 8'h63);
        end
        check(halted_2, 1'b1);
        // A fourth error byte would start within half a bit of the third stop
        repeat (1000) begin
            @(negedge clk);
            if (lnk2.dev_line !== 1'b1) begin
                quiet = 1'b0;
            end
        end
        check(quiet, 1'b1);
    endtask
    // Reset pin revives the halted device; a break as command gives the break code
    task automatic t_break;
        pidq_byte_t b;
        lnk2.dev_reset = 1'b1;
        @(negedge clk);
        lnk2.dev_reset = 1'b0;
        check(halted_2, 1'b0);
        send(8'h86);
        recv(b);
        check(b, 8'h86);
        send(8'h79);
        recv(b);
        check(b, 8'h79);
        // Low past the stop sample, released just before the error reply starts
        lnk2.ctrl_line = 1'b0;
        repeat (819) @(negedge clk);
        lnk2.ctrl_line = 1'b1;
        for (int i = 0; i < 3; i++) begin
            recv(b);
            check(b, 8'ha3);
        end
    endtask

    initial begin
        start = 1'b0;
        match_alt = 1'b0;
        reset = 1'b1;
        lnk2.ctrl_line = 1'b1;
        lnk2.dev_reset = 1'b0;
        repeat (20) @(negedge clk);
        reset = 1'b0;
        query(1'b0);
        query(1'b1);
        t_bad_cmd();
        t_break();
        stop_test();
    end
    initial begin
        repeat (90000) @(posedge clk);
        error_cnt++;
        stop_test();
    end
endmodule
